//--- test/dfh_flash_host_chk.sv
// Purpose: Pin and handshake checks on the flash host
// Assumes: One clock, asynchronous active low reset
// Notes:   Bound to every instance of the host
`timescale 1ns/1ps
module dfh_flash_host_chk (
  // Clock, reset, user side
  input wire logic                       clock_i,
  input wire logic                       nrst_i,
  input wire logic                       cmd_ready_o,
  input wire logic                       done_o,
  input wire logic                       refused_o,
  input wire logic [dfh_pkg::DATA_W-1:0] status_o,
  // Flash pins
  input wire logic                       bank_zero_select_n_o,
  input wire logic                       bank_one_select_n_o,
  input wire logic                       oe_n_o,
  input wire logic                       we_n_o,
  input wire logic [dfh_pkg::ADDR_W-1:0] addr_o,
  input wire logic                       dq_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  chk_one_bank: assert property (
    bank_zero_select_n_o || bank_one_select_n_o) else $error("both banks selected");
  chk_write_len: assert property (
    $fell(we_n_o) && oe_n_o |-> !we_n_o[*8] ##1 we_n_o) else $error("write strobe width");
  chk_write_drive: assert property (
    !we_n_o && oe_n_o |-> dq_oe_o) else $error("data not driven in write");
  chk_read_float: assert property (
    !oe_n_o |-> !dq_oe_o) else $error("host drives data in read");
  chk_status_mask: assert property (
    status_o[2:0] == 3'b000) else $error("reserved status bits kept");
  chk_refuse_quiet: assert property (
    refused_o |-> cmd_ready_o && bank_zero_select_n_o && bank_one_select_n_o)
    else $error("refused lock touched pins");
  chk_done_pulse: assert property (
    done_o |-> cmd_ready_o ##1 !done_o) else $error("done not one pulse");
  chk_addr_setup: assert property (
    $fell(we_n_o) || $fell(oe_n_o) |-> $stable(addr_o)) else $error("address moved at strobe");
endmodule
bind dfh_flash_host dfh_flash_host_chk u_chk (.clock_i, .nrst_i, .cmd_ready_o, .done_o,
  .refused_o, .status_o, .bank_zero_select_n_o, .bank_one_select_n_o, .oe_n_o, .we_n_o,
  .addr_o, .dq_oe_o);

//--- test/dfh_flash_host_tb.sv
// Purpose: Self-checking bench of the flash host
// Assumes: Behavioural flash model on the pins
// Notes:   Each scenario waits on done or refused
`timescale 1ns/1ps
module dfh_flash_host_tb;
  localparam logic [7:0] MK = 8'h5a; // Arbitrary maker code
  localparam logic [7:0] PT = 8'h3c; // Arbitrary part code
  logic clock_i = 0, nrst_i = 0, cmd_valid_i = 0, cmd_bank_i = 0, vpp = 1;
  dfh_pkg::dfh_op_e cmd_op_i = dfh_pkg::OP_READ_ARRAY;
  logic [17:0] cmd_addr_i = 0, addr_o;
  logic [7:0] cmd_data_i = 0, cmd_data2_i = 0, rdata_o, rdata2_o, status_o, dq_o, dq_i;
  logic cmd_ready_o, done_o, refused_o, s0, s1, oe_n, we_n, dq_oe;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  dfh_flash_host dut (.clock_i, .nrst_i, .cmd_valid_i, .cmd_op_i, .cmd_bank_i, .cmd_addr_i,
    .cmd_data_i, .cmd_data2_i, .cmd_ready_o, .done_o, .refused_o, .rdata_o, .rdata2_o,
    .status_o, .bank_zero_select_n_o(s0), .bank_one_select_n_o(s1), .oe_n_o(oe_n),
    .we_n_o(we_n), .addr_o, .dq_o, .dq_oe_o(dq_oe), .dq_i);
  dfh_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) u_dev (.bank_zero_select_n_i(s0),
    .bank_one_select_n_i(s1), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr_o), .dq_o_i(dq_o),
    .dq_oe_i(dq_oe), .vpp_ok_i(vpp), .dq_i);
  always #12.5 clock_i = ~clock_i;
  // Hang guard well above the expected run length
  always @(posedge clock_i) if (++cyc > 60000) begin fail_count++; end_of_test(); end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end
  endtask
  task automatic run(dfh_pkg::dfh_op_e o, logic b, logic [17:0] a, logic [7:0] d = 0,
                     logic [7:0] e = 0);
    @(posedge clock_i);
    cmd_valid_i <= 1; cmd_op_i <= o; cmd_bank_i <= b; cmd_addr_i <= a;
    cmd_data_i <= d; cmd_data2_i <= e;
    @(posedge clock_i);
    cmd_valid_i <= 0;
    while (done_o !== 1'b1 && refused_o !== 1'b1) @(negedge clock_i);
  endtask
  task automatic t_ident;
    run(dfh_pkg::OP_READ_ID, 0, 0);
    chk("maker", rdata_o, MK);
    chk("part", rdata2_o, PT);
  endtask
  task automatic t_write;
    run(dfh_pkg::OP_BYTE_WRITE, 1, 18'h0_0005, 8'ha5);
    chk("wr_status", status_o, 8'h80);
    run(dfh_pkg::OP_READ_ARRAY, 1, 18'h0_0005);
    chk("rd_bank1", rdata_o, 8'ha5);
    run(dfh_pkg::OP_READ_ARRAY, 0, 18'h0_0005);
    chk("rd_bank0", rdata_o, 8'hff);
    run(dfh_pkg::OP_TWO_BYTE, 0, 18'h0_0003, 8'h12, 8'h34);
    run(dfh_pkg::OP_READ_ARRAY, 0, 18'h0_0002);
    chk("two_byte", rdata_o, 8'h34);
  endtask
  task automatic t_supply;
    @(posedge clock_i) vpp <= 0;
    run(dfh_pkg::OP_BYTE_WRITE, 0, 18'h0_0001, 8'h0f);
    chk("supply_low", status_o, 8'h98);
    vpp <= 1;
    run(dfh_pkg::OP_CLEAR_STATUS, 0, 0);
    run(dfh_pkg::OP_READ_STATUS, 0, 0);
    chk("cleared", status_o, 8'h80);
  endtask
  task automatic t_lock;
    run(dfh_pkg::OP_LOCK_BLOCK, 0, 0);
    chk("refused", {7'h00, refused_o}, 8'h01);
    run(dfh_pkg::OP_PROTECT_RESET, 0, 0);
    run(dfh_pkg::OP_LOCK_BLOCK, 0, 18'h0_4000);
    chk("locked", {7'h00, done_o}, 8'h01);
    run(dfh_pkg::OP_BANK_ERASE, 1, 0);
    run(dfh_pkg::OP_READ_ARRAY, 1, 18'h0_0005);
    chk("erased", rdata_o, 8'hff);
    run(dfh_pkg::OP_SUSPEND, 1, 0);
    run(dfh_pkg::OP_BLOCK_ERASE, 1, 18'h0_4005);
    chk("resumed", {7'h00, done_o}, 8'h01);
    run(dfh_pkg::OP_BANK_RESET, 0, 0);
    chk("bank_rst", status_o, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1;
    @(negedge clock_i);
    chk("ready", {7'h00, cmd_ready_o}, 8'h01);
    t_ident();
    t_write();
    t_supply();
    t_lock();
    end_of_test();
  end
endmodule

//--- test/dfh_flash_model.sv
// Purpose: Behavioural two bank flash on the host pins
// Assumes: 16 bytes of array per bank, status busy for two polls
// Notes:   Codes are arbitrary values
`timescale 1ns/1ps
module dfh_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] PART_CODE  = 8'h3c
) (
  input  wire logic        bank_zero_select_n_i,
  input  wire logic        bank_one_select_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_o_i,
  input  wire logic        dq_oe_i,
  input  wire logic        vpp_ok_i,
  output logic [7:0]       dq_i
);
  logic [7:0] m [2][16];
  logic [7:0] st [2];
  logic [7:0] pc [2];
  logic [1:0] md [2];
  logic [1:0] bz [2];
  logic       b;
  logic       rd;
  logic [7:0] q;
  // Bank index from the selects; banks keep separate state
  assign b = bank_zero_select_n_i;
  assign rd = !(bank_zero_select_n_i && bank_one_select_n_i) && !oe_n_i && we_n_i;
  // Reserved bits read as ones so the host must mask them
  assign q = md[b] == 2 ? {bz[b] == 0, st[b][6:3], 3'b111} :
             md[b] == 1 ? (addr_i[0] ? PART_CODE : MAKER_CODE) : m[b][addr_i[3:0]];
  // No pull-up: a released bus shows the inverse
  assign dq_i = rd ? q : dq_oe_i ? dq_o_i : ~q;
  initial for (int i = 0; i < 32; i++) m[i/16][i%16] = 8'hff;
  initial begin
    st = '{8'h00, 8'h00};
    pc = '{8'h00, 8'h00};
    md = '{2'd0, 2'd0};
    bz = '{2'd0, 2'd0};
  end
  // Start of a long operation shows status at once
  task automatic start(logic [7:0] k);
    md[b] = 2;
    bz[b] = 2;
    if (!vpp_ok_i) st[b] |= 8'h08 | k;
  endtask
  always @(posedge oe_n_i) if (md[b] == 2 && bz[b] != 0) bz[b]--;
  // Commands take effect at the trailing write edge
  always @(posedge we_n_i) begin
    case (pc[b])
      8'h40, 8'h10: begin m[b][addr_i[3:0]] = dq_o_i; start(8'h10); pc[b] = 0; end
      8'hfb: begin m[b][addr_i[3:0]] = dq_o_i; pc[b] = 8'hfc; end
      8'hfc: begin m[b][{addr_i[3:1], ~addr_i[0]}] = dq_o_i; start(8'h10); pc[b] = 0; end
      8'h20, 8'ha7: begin
        if (dq_o_i != 8'hd0) st[b] |= 8'h30;
        else if (pc[b] == 8'ha7) for (int j = 0; j < 16; j++) m[b][j] = 8'hff;
        if (dq_o_i == 8'hd0) start(8'h20);
        pc[b] = 0;
      end
      default: begin
        pc[b] = dq_o_i;
        md[b] = dq_o_i == 8'h90 ? 2'd1 : dq_o_i == 8'hff ? 2'd0 : 2'd2;
        if (dq_o_i == 8'h50) st[b] &= 8'hc7;
      end
    endcase
  end
endmodule

//--- verilog/dfh_cyc_if.sv
// Purpose: Carrier between the command sequencer and the bus cycle engine
// Assumes: req and ack are one-cycle pulses on the system clock
// Notes:   Fields stand stable from req until ack
`timescale 1ns/1ps
interface dfh_cyc_if;
  logic                          req;
  dfh_pkg::dfh_cyc_e             kind;
  logic                          bank;
  logic [dfh_pkg::ADDR_W-1:0]    addr;
  logic [dfh_pkg::DATA_W-1:0]    wdata;
  logic                          ack;
  logic [dfh_pkg::DATA_W-1:0]    rdata;

  modport seq (output req, kind, bank, addr, wdata, input ack, rdata);
  modport eng (input req, kind, bank, addr, wdata, output ack, rdata);
endinterface

//--- verilog/dfh_cycle_engine.sv
// Purpose: Drives single read, write and bank reset cycles on the flash pins
// Assumes: One request at a time, next request only after ack
// Notes:   All pin outputs are flip-flops; data pins pass three flops
`timescale 1ns/1ps
module dfh_cycle_engine (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       nrst_i,
  // Sequencer side
  dfh_cyc_if.eng                          cyc,
  // Flash pins
  output logic                            bank_zero_select_n_o,
  output logic                            bank_one_select_n_o,
  output logic                            oe_n_o,
  output logic                            we_n_o,
  output logic [dfh_pkg::ADDR_W-1:0]      addr_o,
  output logic [dfh_pkg::DATA_W-1:0]      dq_o,
  output logic                            dq_oe_o,
  input  wire logic [dfh_pkg::DATA_W-1:0] dq_i
);

  // ****************************************************************
  // State and synchroniser
  // ****************************************************************
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_RECOVER} dfh_eng_state_e;

  dfh_eng_state_e               state_r;
  dfh_pkg::dfh_cyc_e            kind_r;
  logic [dfh_pkg::CNT_W-1:0]    cnt_r;
  logic [dfh_pkg::DATA_W-1:0]   dq_s1_r;
  logic [dfh_pkg::DATA_W-1:0]   dq_s2_r;
  logic [dfh_pkg::DATA_W-1:0]   dq_s3_r;
  logic                         ack_r;
  logic [dfh_pkg::DATA_W-1:0]   rdata_r;

  // Pulse length per cycle kind; reads add the synchroniser latency
  wire [dfh_pkg::CNT_W-1:0] pulse_len_w =
    (kind_r == dfh_pkg::CYC_RESET) ? dfh_pkg::CNT_W'(dfh_pkg::BANK_RESET_CYC) :
    (kind_r == dfh_pkg::CYC_READ)  ? dfh_pkg::CNT_W'(dfh_pkg::ACCESS_CYC + dfh_pkg::SYNC_CYC) :
                                     dfh_pkg::CNT_W'(dfh_pkg::ACCESS_CYC);
  // Sampled data counts only once the last two stages agree
  wire dq_stable_w = (dq_s2_r == dq_s3_r);
  wire pulse_end_w = (cnt_r == '0) && ((kind_r != dfh_pkg::CYC_READ) || dq_stable_w);

  assign cyc.ack   = ack_r;
  assign cyc.rdata = rdata_r;

  // Data pin synchroniser, first stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dq_s3_r <= '0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  // ****************************************************************
  // Cycle sequencing
  // ****************************************************************
  // Address set up one cycle ahead of the strobe, bank selects released one after
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r              <= E_IDLE;
      kind_r               <= dfh_pkg::CYC_WRITE;
      cnt_r                <= '0;
      ack_r                <= 1'b0;
      rdata_r              <= '0;
      bank_zero_select_n_o <= 1'b1;
      bank_one_select_n_o  <= 1'b1;
      oe_n_o               <= 1'b1;
      we_n_o               <= 1'b1;
      addr_o               <= '0;
      dq_o                 <= '0;
      dq_oe_o              <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      unique case (state_r)
        E_IDLE: begin
          if (cyc.req) begin
            kind_r               <= cyc.kind;
            addr_o               <= cyc.addr;
            dq_o                 <= cyc.wdata;
            dq_oe_o              <= (cyc.kind == dfh_pkg::CYC_WRITE);
            bank_zero_select_n_o <= cyc.bank;
            bank_one_select_n_o  <= !cyc.bank;
            state_r              <= E_SETUP;
          end
        end
        E_SETUP: begin
          cnt_r   <= pulse_len_w - 1'b1;
          we_n_o  <= (kind_r == dfh_pkg::CYC_READ);
          oe_n_o  <= (kind_r == dfh_pkg::CYC_WRITE);
          state_r <= E_PULSE;
        end
        E_PULSE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end
          if (pulse_end_w) begin
            rdata_r <= dq_s3_r;
            we_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            state_r <= E_HOLD;
          end
        end
        E_HOLD: begin
          bank_zero_select_n_o <= 1'b1;
          bank_one_select_n_o  <= 1'b1;
          dq_oe_o              <= 1'b0;
          if (kind_r == dfh_pkg::CYC_RESET) begin
            cnt_r   <= dfh_pkg::CNT_W'(dfh_pkg::RECOVER_CYC);
            state_r <= E_RECOVER;
          end else begin
            ack_r   <= 1'b1;
            state_r <= E_IDLE;
          end
        end
        E_RECOVER: begin
          // Reset released: wait before the bank answers again
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == 1) begin
            ack_r   <= 1'b1;
            state_r <= E_IDLE;
          end
        end
        default: state_r <= E_IDLE;
      endcase
    end
  end

endmodule

//--- verilog/dfh_flash_host.sv
// Purpose: Host controller issuing command sequences to a dual-bank flash
// Assumes: User waits for cmd_ready_o before each command
// Notes:   Long operations are polled on the status byte until ready
`timescale 1ns/1ps
module dfh_flash_host (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  // User command port
  input  wire logic                        cmd_valid_i,
  input  wire dfh_pkg::dfh_op_e            cmd_op_i,
  input  wire logic                        cmd_bank_i,
  input  wire logic [dfh_pkg::ADDR_W-1:0]  cmd_addr_i,
  input  wire logic [dfh_pkg::DATA_W-1:0]  cmd_data_i,
  input  wire logic [dfh_pkg::DATA_W-1:0]  cmd_data2_i,
  // User answer port
  output logic                             cmd_ready_o,
  output logic                             done_o,
  output logic                             refused_o,
  output logic [dfh_pkg::DATA_W-1:0]       rdata_o,
  output logic [dfh_pkg::DATA_W-1:0]       rdata2_o,
  output logic [dfh_pkg::DATA_W-1:0]       status_o,
  // Flash pins
  output logic                             bank_zero_select_n_o,
  output logic                             bank_one_select_n_o,
  output logic                             oe_n_o,
  output logic                             we_n_o,
  output logic [dfh_pkg::ADDR_W-1:0]       addr_o,
  output logic [dfh_pkg::DATA_W-1:0]       dq_o,
  output logic                             dq_oe_o,
  input  wire logic [dfh_pkg::DATA_W-1:0]  dq_i
);

  // ****************************************************************
  // Command sequence table
  // ****************************************************************
  // One entry per bus cycle of a command; poll means wait for ready after it
  function automatic dfh_pkg::dfh_step_s step_of(
    input dfh_pkg::dfh_op_e          op,
    input logic [1:0]                idx,
    input logic [dfh_pkg::ADDR_W-1:0] a,
    input logic [dfh_pkg::DATA_W-1:0] d0,
    input logic [dfh_pkg::DATA_W-1:0] d1
  );
    dfh_pkg::dfh_step_s s;
    s.kind = dfh_pkg::CYC_WRITE;
    s.addr = dfh_pkg::ADDR_ZERO;
    s.data = dfh_pkg::CMD_CONFIRM;
    s.poll = 1'b0;
    s.last = 1'b0;
    if (op == dfh_pkg::OP_READ_ARRAY) begin
      if (idx == 2'd0) s.data = dfh_pkg::CMD_READ_ARRAY;
      else begin
        s.kind = dfh_pkg::CYC_READ;
        s.addr = a;
        s.last = 1'b1;
      end
    end else if (op == dfh_pkg::OP_READ_ID) begin
      if (idx == 2'd0) s.data = dfh_pkg::CMD_READ_ID;
      else begin
        s.kind = dfh_pkg::CYC_READ;
        s.addr = (idx == 2'd1) ? dfh_pkg::ADDR_ZERO : dfh_pkg::ADDR_ID_PART;
        s.last = (idx == 2'd2);
      end
    end else if (op == dfh_pkg::OP_READ_STATUS) begin
      if (idx == 2'd0) s.data = dfh_pkg::CMD_READ_STATUS;
      else begin
        s.kind = dfh_pkg::CYC_READ;
        s.last = 1'b1;
      end
    end else if (op == dfh_pkg::OP_CLEAR_STATUS) begin
      s.data = dfh_pkg::CMD_CLEAR_STATUS;
      s.last = 1'b1;
    end else if (op == dfh_pkg::OP_SUSPEND) begin
      s.data = dfh_pkg::CMD_SUSPEND;
      s.poll = 1'b1;
      s.last = 1'b1;
    end else if (op == dfh_pkg::OP_RESUME) begin
      s.last = 1'b1;
    end else if (op == dfh_pkg::OP_BANK_RESET) begin
      s.kind = dfh_pkg::CYC_RESET;
      s.last = 1'b1;
    end else if (op == dfh_pkg::OP_TWO_BYTE) begin
      if (idx == 2'd0) s.data = dfh_pkg::CMD_TWO_BYTE;
      else begin
        s.addr = a;
        s.data = (idx == 2'd1) ? d0 : d1;
        s.poll = (idx == 2'd2);
        s.last = idx[1];
      end
    end else if (op == dfh_pkg::OP_LOCK_BLOCK) begin
      // Protect set follows the lock so lock status tracks the bits
      unique case (idx)
        2'd0: s.data = dfh_pkg::CMD_LOCK_BLOCK;
        2'd1: begin
          s.addr = a;
          s.poll = 1'b1;
        end
        2'd2: s.data = dfh_pkg::CMD_PROTECT_SET;
        2'd3: begin
          s.addr = dfh_pkg::ADDR_PROT_CONF;
          s.last = 1'b1;
        end
      endcase
    end else if (idx == 2'd0) begin
      // First cycle of the remaining two-cycle commands
      unique case (op)
        dfh_pkg::OP_BYTE_WRITE:    s.data = dfh_pkg::CMD_BYTE_WRITE;
        dfh_pkg::OP_BLOCK_ERASE:   s.data = dfh_pkg::CMD_BLOCK_ERASE;
        dfh_pkg::OP_BANK_ERASE:    s.data = dfh_pkg::CMD_BANK_ERASE;
        dfh_pkg::OP_PROTECT_SET:   s.data = dfh_pkg::CMD_PROTECT_SET;
        default:                   s.data = dfh_pkg::CMD_PROTECT_RST;
      endcase
    end else begin
      s.last = 1'b1;
      unique case (op)
        dfh_pkg::OP_BYTE_WRITE: begin
          s.addr = a;
          s.data = d0;
          s.poll = 1'b1;
        end
        dfh_pkg::OP_BLOCK_ERASE: begin
          s.addr = a;
          s.poll = 1'b1;
        end
        dfh_pkg::OP_BANK_ERASE:  s.poll = 1'b1;
        default:                 s.addr = dfh_pkg::ADDR_PROT_CONF;
      endcase
    end
    return s;
  endfunction

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT, S_FINISH, S_RESUME, S_RESUME_WAIT
  } dfh_seq_state_e;

  dfh_seq_state_e                state_r;
  dfh_pkg::dfh_op_e              op_r;
  logic                          bank_r;
  logic [dfh_pkg::ADDR_W-1:0]    addr_r;
  logic [dfh_pkg::DATA_W-1:0]    d0_r;
  logic [dfh_pkg::DATA_W-1:0]    d1_r;
  logic [1:0]                    idx_r;
  logic [1:0]                    prot_reset_r;   // Per bank: protect reset in force
  logic [1:0]                    resume_owed_r;  // Per bank: resume after next erase
  logic                          req_r;
  dfh_pkg::dfh_cyc_e             kind_r;
  logic [dfh_pkg::ADDR_W-1:0]    caddr_r;
  logic [dfh_pkg::DATA_W-1:0]    cdata_r;

  dfh_cyc_if cyc ();

  wire dfh_pkg::dfh_step_s step_w = step_of(op_r, idx_r, addr_r, d0_r, d1_r);
  wire [dfh_pkg::DATA_W-1:0] status_masked_w = cyc.rdata & dfh_pkg::STATUS_MASK;
  wire engine_ready_w  = cyc.rdata[dfh_pkg::ST_READY];
  wire is_erase_w      = (op_r == dfh_pkg::OP_BLOCK_ERASE) || (op_r == dfh_pkg::OP_BANK_ERASE);
  wire lock_refused_w  = (cmd_op_i == dfh_pkg::OP_LOCK_BLOCK) && !prot_reset_r[cmd_bank_i];

  assign cyc.req   = req_r;
  assign cyc.kind  = kind_r;
  assign cyc.bank  = bank_r;
  assign cyc.addr  = caddr_r;
  assign cyc.wdata = cdata_r;

  // Pin cycle engine, one bank at a time
  dfh_cycle_engine u_engine (
    .clock_i              (clock_i),
    .nrst_i               (nrst_i),
    .cyc                  (cyc),
    .bank_zero_select_n_o (bank_zero_select_n_o),
    .bank_one_select_n_o  (bank_one_select_n_o),
    .oe_n_o               (oe_n_o),
    .we_n_o               (we_n_o),
    .addr_o               (addr_o),
    .dq_o                 (dq_o),
    .dq_oe_o              (dq_oe_o),
    .dq_i                 (dq_i)
  );

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  // Each long operation is polled to ready before the next command on either bank
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r       <= S_IDLE;
      op_r          <= dfh_pkg::OP_READ_ARRAY;
      bank_r        <= 1'b0;
      addr_r        <= '0;
      d0_r          <= '0;
      d1_r          <= '0;
      idx_r         <= '0;
      prot_reset_r  <= '0;
      resume_owed_r <= '0;
      req_r         <= 1'b0;
      kind_r        <= dfh_pkg::CYC_WRITE;
      caddr_r       <= '0;
      cdata_r       <= '0;
      cmd_ready_o   <= 1'b1;
      done_o        <= 1'b0;
      refused_o     <= 1'b0;
      rdata_o       <= '0;
      rdata2_o      <= '0;
      status_o      <= '0;
    end else begin
      req_r     <= 1'b0;
      done_o    <= 1'b0;
      refused_o <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (cmd_valid_i && lock_refused_w) begin
            refused_o <= 1'b1;
          end else if (cmd_valid_i) begin
            op_r        <= cmd_op_i;
            bank_r      <= cmd_bank_i;
            addr_r      <= cmd_addr_i;
            d0_r        <= cmd_data_i;
            d1_r        <= cmd_data2_i;
            idx_r       <= '0;
            cmd_ready_o <= 1'b0;
            state_r     <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          req_r   <= 1'b1;
          kind_r  <= step_w.kind;
          caddr_r <= step_w.addr;
          cdata_r <= step_w.data;
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc.ack) begin
            if (step_w.kind == dfh_pkg::CYC_READ && idx_r == 2'd2) rdata2_o <= cyc.rdata;
            else if (step_w.kind == dfh_pkg::CYC_READ) rdata_o <= cyc.rdata;
            if (op_r == dfh_pkg::OP_READ_STATUS) status_o <= status_masked_w;
            idx_r   <= idx_r + 1'b1;
            state_r <= step_w.poll ? S_POLL : (step_w.last ? S_FINISH : S_ISSUE);
          end
        end
        S_POLL: begin
          // Bank already shows status after the command, no 70H needed
          req_r   <= 1'b1;
          kind_r  <= dfh_pkg::CYC_READ;
          caddr_r <= dfh_pkg::ADDR_ZERO;
          state_r <= S_POLL_WAIT;
        end
        S_POLL_WAIT: begin
          if (cyc.ack) begin
            // Flags 6..3 only meaningful once ready is seen
            status_o <= status_masked_w;
            if (!engine_ready_w) begin
              state_r <= S_POLL;
            end else begin
              if (op_r == dfh_pkg::OP_SUSPEND && !cyc.rdata[dfh_pkg::ST_SUSPENDED]) begin
                resume_owed_r[bank_r] <= 1'b1;
              end
              state_r <= step_w.last ? S_FINISH : S_ISSUE;
            end
          end
        end
        S_FINISH: begin
          if (op_r == dfh_pkg::OP_PROTECT_RESET) prot_reset_r[bank_r] <= 1'b1;
          if (op_r == dfh_pkg::OP_PROTECT_SET || op_r == dfh_pkg::OP_LOCK_BLOCK ||
              op_r == dfh_pkg::OP_BANK_RESET) begin
            prot_reset_r[bank_r] <= 1'b0;
          end
          if (op_r == dfh_pkg::OP_BANK_RESET) resume_owed_r[bank_r] <= 1'b0;
          if (op_r == dfh_pkg::OP_BANK_RESET) status_o <= '0;
          if (is_erase_w && resume_owed_r[bank_r]) begin
            resume_owed_r[bank_r] <= 1'b0;
            state_r               <= S_RESUME;
          end else begin
            done_o      <= 1'b1;
            cmd_ready_o <= 1'b1;
            state_r     <= S_IDLE;
          end
        end
        S_RESUME: begin
          req_r   <= 1'b1;
          kind_r  <= dfh_pkg::CYC_WRITE;
          caddr_r <= dfh_pkg::ADDR_ZERO;
          cdata_r <= dfh_pkg::CMD_CONFIRM;
          state_r <= S_RESUME_WAIT;
        end
        S_RESUME_WAIT: begin
          if (cyc.ack) begin
            done_o      <= 1'b1;
            cmd_ready_o <= 1'b1;
            state_r     <= S_IDLE;
          end
        end
      endcase
    end
  end

endmodule

//--- verilog/dfh_pkg.sv
// Purpose: Shared constants and types of the dual-bank flash host controller
// Assumes: 40 MHz system clock, 18 address pins, 8-bit data bus
// Notes:   Times are kept in ns; cycle counts derive from the clock period
package dfh_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int ADDR_W         = 18;
  localparam int DATA_W         = 8;
  localparam int CNT_W          = 8;
  localparam int CLK_PERIOD_NS  = 25;
  // Strobe width, covers the slowest read access of the part
  localparam int ACCESS_NS      = 200;
  localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Data pins pass a three stage synchroniser before use
  localparam int SYNC_CYC       = 3;
  // Bank reset needs the strobes low for longer than this time
  localparam int BANK_RESET_NS  = 5000;
  localparam int BANK_RESET_CYC = BANK_RESET_NS / CLK_PERIOD_NS + 1;
  // Output data not valid until this long after the reset is released
  localparam int RECOVER_NS     = 750;
  localparam int RECOVER_CYC    = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Command codes and addresses
  // ****************************************************************
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [DATA_W-1:0] CMD_READ_ID      = 8'h90;
  localparam logic [DATA_W-1:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [DATA_W-1:0] CMD_BYTE_WRITE   = 8'h40;
  localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [DATA_W-1:0] CMD_SUSPEND      = 8'hb0;
  localparam logic [DATA_W-1:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [DATA_W-1:0] CMD_PROTECT_SET  = 8'h57;
  localparam logic [DATA_W-1:0] CMD_PROTECT_RST  = 8'h47;
  localparam logic [DATA_W-1:0] CMD_LOCK_BLOCK   = 8'h77;
  localparam logic [DATA_W-1:0] CMD_BANK_ERASE   = 8'ha7;
  localparam logic [DATA_W-1:0] CMD_TWO_BYTE     = 8'hfb;
  localparam logic [ADDR_W-1:0] ADDR_ZERO        = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_ID_PART     = 18'h0_0001;
  localparam logic [ADDR_W-1:0] ADDR_PROT_CONF   = 18'h0_00ff;

  // ****************************************************************
  // Operation status byte
  // ****************************************************************
  localparam int ST_READY      = 7;
  localparam int ST_SUSPENDED  = 6;
  localparam int ST_ERASE_FAIL = 5;
  localparam int ST_WRITE_FAIL = 4;
  localparam int ST_SUPPLY_LOW = 3;
  localparam logic [DATA_W-1:0] STATUS_MASK = 8'hf8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS, OP_CLEAR_STATUS,
    OP_BYTE_WRITE, OP_BLOCK_ERASE, OP_SUSPEND, OP_RESUME,
    OP_PROTECT_SET, OP_PROTECT_RESET, OP_LOCK_BLOCK, OP_BANK_ERASE,
    OP_TWO_BYTE, OP_BANK_RESET
  } dfh_op_e;

  typedef enum logic [1:0] {CYC_WRITE, CYC_READ, CYC_RESET} dfh_cyc_e;

  typedef struct packed {
    dfh_cyc_e              kind;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
    logic                  poll;
    logic                  last;
  } dfh_step_s;

endpackage
